// [common/acr_defines.vh]
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH

// control-port offsets on page 0 of book 0
`define ACR_OFS_PAGE 7'h00
`define ACR_OFS_BOOK 7'h7f
`define ACR_OFS_RESET_CONTROL 7'h01
`define ACR_OFS_POWER_STAGE 7'h02
`define ACR_OFS_DEVICE_STATE 7'h03
`define ACR_OFS_PAGE_WRAP 7'h0f
`define ACR_OFS_SAMPLE_RATE 7'h28
`define ACR_OFS_CLOCK_DETECT_CFG 7'h29
`define ACR_OFS_SERIAL_OUT_SEL 7'h30
`define ACR_OFS_AUDIO_FORMAT 7'h31
`define ACR_OFS_AUDIO_CFG_A 7'h33
`define ACR_OFS_AUDIO_CFG_B 7'h34
`define ACR_OFS_AUDIO_CFG_C 7'h35
`define ACR_OFS_SAMPLE_RATE_MON 7'h37
`define ACR_OFS_BIT_CLOCK_MON 7'h38
`define ACR_OFS_CLOCK_DETECT_FLAGS 7'h39
`define ACR_OFS_PROC_PGM_MODE 7'h40
`define ACR_OFS_PROC_CONTROL 7'h46
`define ACR_OFS_DIGITAL_VOLUME 7'h4c
`define ACR_OFS_VOL_RAMP_A 7'h4e
`define ACR_OFS_VOL_RAMP_B 7'h4f
`define ACR_OFS_SILENCE_MUTE_CFG 7'h50
`define ACR_OFS_SILENCE_MUTE_DELAY 7'h51
`define ACR_OFS_ANALOG_CONTROL 7'h53
`define ACR_OFS_ANALOG_GAIN 7'h54
`define ACR_OFS_SPI_CLOCK 7'h55
`define ACR_OFS_BOOT_CONTROL 7'h56
`define ACR_OFS_BOOT_READ_CMD 7'h57
`define ACR_OFS_BOOT_ADDR_0 7'h58
`define ACR_OFS_BOOT_ADDR_1 7'h59
`define ACR_OFS_BOOT_ADDR_2 7'h5a
`define ACR_OFS_BOOT_STATUS 7'h5b
`define ACR_OFS_FILTER_WRITE 7'h5c
`define ACR_OFS_SUPPLY_READING 7'h5e
`define ACR_OFS_PIN_DIRECTION 7'h60
`define ACR_OFS_PIN0_FUNCTION 7'h61
`define ACR_OFS_PIN1_FUNCTION 7'h62
`define ACR_OFS_PIN2_FUNCTION 7'h63
`define ACR_OFS_PIN_INPUT_FUNCTION 7'h64
`define ACR_OFS_PIN_OUTPUT_VALUE 7'h65
`define ACR_OFS_PIN_OUTPUT_INVERT 7'h66
`define ACR_OFS_DIE_REVISION 7'h67
`define ACR_OFS_POWER_STATE 7'h68
`define ACR_OFS_MUTE_STATE 7'h69
`define ACR_OFS_PHASE_CONTROL 7'h6a
`define ACR_OFS_SPREAD_0 7'h6b
`define ACR_OFS_SPREAD_1 7'h6c
`define ACR_OFS_SPREAD_2 7'h6d
`define ACR_OFS_SPREAD_3 7'h6e
`define ACR_OFS_SPREAD_4 7'h6f

// writable-bit masks and reset values
`define ACR_MASK_FULL 8'hff
`define ACR_MASK_NONE 8'h00
`define ACR_MASK_POWER_STAGE 8'h77
`define ACR_MASK_DEVICE_STATE 8'h1b
`define ACR_MASK_PAGE_WRAP 8'h08
`define ACR_MASK_SAMPLE_RATE 8'hf8
`define ACR_RST_ZERO 8'h00
`define ACR_RST_DEVICE_STATE 8'h10

// field positions
`define ACR_FULL_RESET_BIT 4
`define ACR_REG_RESET_BIT 0
`define ACR_FSW_MSB 6
`define ACR_FSW_LSB 4
`define ACR_PARALLEL_BRIDGE_BIT 2
`define ACR_MOD_MSB 1
`define ACR_MOD_LSB 0
`define ACR_DSP_HOLD_BIT 4
`define ACR_MUTE_BIT 3
`define ACR_STATE_MSB 1
`define ACR_STATE_LSB 0

// field codes
`define ACR_FSW_384K 3'h0
`define ACR_FSW_480K 3'h2
`define ACR_FSW_576K 3'h3
`define ACR_FSW_768K 3'h4
`define ACR_MOD_TWO_LEVEL 2'h0
`define ACR_MOD_SINGLE_SIDED 2'h1
`define ACR_MOD_HYBRID 2'h2

// serial byte length in bits
`define ACR_BYTE_BITS 4'h8

`endif

// [hw/acr_amp_control_register_bank.v]
// Contract
// - writing one to reset-control bit 4 resets processor, coefficients and all registers
// - full core reset clears the whole coefficient memory, reads then give zero
// - writing one to reset-control bit 0 restores every control register to reset
// - register-only reset leaves coefficient memory untouched
// - both reset bits are write-only and read back zero without a clearing write
// - power-stage bits 6..4 pick switching frequency 384K, 480K, 576K or 768K
// - power-stage bit 2 picks bridge-tied load (0) or parallel bridge (1)
// - power-stage bits 1..0 pick two-level, single-sided or hybrid modulation
// - power-stage register reads 0x00 after reset
// - device-state bits 1..0 pick deep sleep, sleep, high-impedance or play
// - offset 0x00 of every page selects page, 0x7f of page 0 selects book
`timescale 1ns/10ps
`default_nettype none
`include "acr_defines.vh"

module acr_amp_control_register_bank #(
  parameter [6:0] DEV_ADDR = 7'h2a,
  parameter [7:0] DIE_REVISION = 8'h5a,
  parameter COEF_PAGE_BITS = 1
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  output wire o_sda_out,
  output wire o_sda_oe,
  output wire [2:0] o_switching_frequency_select,
  output wire o_parallel_bridge_select,
  output wire [1:0] o_modulation_scheme_select,
  output wire o_power_stage_valid,
  output wire [1:0] o_device_state,
  output wire o_dsp_hold,
  output wire o_mute,
  output wire o_full_core_reset,
  output wire o_coef_clear_busy,
  output wire [7:0] o_page,
  output wire [7:0] o_book
);

  // die revision value above is arbitrary
  localparam COEF_AW = COEF_PAGE_BITS + 7;
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_SUB = 7'h04;
  localparam [6:0] ST_WR = 7'h08;
  localparam [6:0] ST_ACK = 7'h10;
  localparam [6:0] ST_RD = 7'h20;
  localparam [6:0] ST_RACK = 7'h40;

  reg [2:0] scl_sync_q;
  reg [2:0] sda_sync_q;
  reg [6:0] st_q;
  reg [6:0] nxt_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg [7:0] tx_q;
  reg [7:0] sub_q;
  reg oe_q;
  reg hack_q;
  reg wr_stb_q;
  reg [7:0] wr_addr_q;
  reg [7:0] wr_data_q;
  reg [7:0] ctl_q [0:127];
  reg [7:0] coef_q [0:(1 << COEF_AW) - 1];
  reg [7:0] page_q;
  reg [7:0] book_q;
  reg full_rst_q;
  reg reg_rst_q;
  reg clr_busy_q;
  reg [COEF_AW-1:0] clr_cnt_q;
  reg valid_q;
  reg [7:0] rd_data;
  integer i;
  wire [7:0] pwr_cfg = ctl_q[`ACR_OFS_POWER_STAGE]; // power-stage view
  wire [7:0] dev_state = ctl_q[`ACR_OFS_DEVICE_STATE]; // device-state view

  // writable bits per offset; reserved, read-only and unmapped bits stay at reset
  function [7:0] acr_mask;
    input [6:0] a;
    begin
      case (a)
        `ACR_OFS_POWER_STAGE: acr_mask = `ACR_MASK_POWER_STAGE;
        `ACR_OFS_DEVICE_STATE: acr_mask = `ACR_MASK_DEVICE_STATE;
        `ACR_OFS_PAGE_WRAP: acr_mask = `ACR_MASK_PAGE_WRAP;
        `ACR_OFS_SAMPLE_RATE: acr_mask = `ACR_MASK_SAMPLE_RATE;
        `ACR_OFS_CLOCK_DETECT_CFG, `ACR_OFS_SERIAL_OUT_SEL, `ACR_OFS_AUDIO_FORMAT,
        `ACR_OFS_AUDIO_CFG_A, `ACR_OFS_AUDIO_CFG_B, `ACR_OFS_AUDIO_CFG_C,
        `ACR_OFS_PROC_PGM_MODE, `ACR_OFS_PROC_CONTROL, `ACR_OFS_DIGITAL_VOLUME,
        `ACR_OFS_VOL_RAMP_A, `ACR_OFS_VOL_RAMP_B, `ACR_OFS_SILENCE_MUTE_CFG,
        `ACR_OFS_SILENCE_MUTE_DELAY, `ACR_OFS_ANALOG_CONTROL, `ACR_OFS_ANALOG_GAIN,
        `ACR_OFS_SPI_CLOCK, `ACR_OFS_BOOT_CONTROL, `ACR_OFS_BOOT_READ_CMD,
        `ACR_OFS_BOOT_ADDR_0, `ACR_OFS_BOOT_ADDR_1, `ACR_OFS_BOOT_ADDR_2,
        `ACR_OFS_FILTER_WRITE, `ACR_OFS_PIN_DIRECTION, `ACR_OFS_PIN0_FUNCTION,
        `ACR_OFS_PIN1_FUNCTION, `ACR_OFS_PIN2_FUNCTION, `ACR_OFS_PIN_INPUT_FUNCTION,
        `ACR_OFS_PIN_OUTPUT_VALUE, `ACR_OFS_PIN_OUTPUT_INVERT, `ACR_OFS_PHASE_CONTROL,
        `ACR_OFS_SPREAD_0, `ACR_OFS_SPREAD_1, `ACR_OFS_SPREAD_2, `ACR_OFS_SPREAD_3,
        `ACR_OFS_SPREAD_4: acr_mask = `ACR_MASK_FULL;
        default: acr_mask = `ACR_MASK_NONE;
      endcase
    end
  endfunction

  // reset value per offset
  function [7:0] acr_rst_val;
    input [6:0] a;
    begin
      if (a == `ACR_OFS_DEVICE_STATE) begin
        acr_rst_val = `ACR_RST_DEVICE_STATE;
      end else begin
        acr_rst_val = `ACR_RST_ZERO;
      end
    end
  endfunction

  // pin synchronisers; stage 0 feeds stage 1 only, stage 2 is edge history
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], i_scl};
      sda_sync_q <= {sda_sync_q[1:0], i_sda};
    end
  end

  wire scl_rise = scl_sync_q[1] & ~scl_sync_q[2];
  wire scl_fall = ~scl_sync_q[1] & scl_sync_q[2];
  wire scl_high = scl_sync_q[1] & scl_sync_q[2];
  wire bus_start = scl_high & ~sda_sync_q[1] & sda_sync_q[2];
  wire bus_stop = scl_high & sda_sync_q[1] & ~sda_sync_q[2];
  wire sda_bit = sda_sync_q[1];

  // serial slave: bits sampled on scl rise, sda changed on scl fall
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_q <= ST_IDLE;
      nxt_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      sub_q <= 8'h00;
      oe_q <= 1'b0;
      hack_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (bus_start) begin
        st_q <= ST_ADDR;
        cnt_q <= 4'h0;
        oe_q <= 1'b0;
      end else if (bus_stop) begin
        st_q <= ST_IDLE;
        oe_q <= 1'b0;
      end else begin
        case (st_q)
          ST_ADDR, ST_SUB, ST_WR: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_bit};
              cnt_q <= cnt_q + 4'h1;
            end
            if (scl_fall && cnt_q == `ACR_BYTE_BITS) begin
              cnt_q <= 4'h0;
              oe_q <= 1'b1;
              st_q <= ST_ACK;
              if (st_q == ST_ADDR) begin
                nxt_q <= sh_q[0] ? ST_RD : ST_SUB;
                // foreign address: stay off the bus until the next start
                if (sh_q[7:1] != DEV_ADDR) begin
                  oe_q <= 1'b0;
                  st_q <= ST_IDLE;
                end
              end else if (st_q == ST_SUB) begin
                sub_q <= sh_q;
                nxt_q <= ST_WR;
              end else begin
                wr_stb_q <= 1'b1;
                wr_addr_q <= sub_q;
                wr_data_q <= sh_q;
                sub_q <= sub_q + 8'h01;
                nxt_q <= ST_WR;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              if (nxt_q == ST_RD) begin
                tx_q <= rd_data;
                oe_q <= ~rd_data[7];
              end else begin
                oe_q <= 1'b0;
              end
              st_q <= nxt_q;
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end
            if (scl_fall) begin
              if (cnt_q == `ACR_BYTE_BITS) begin
                cnt_q <= 4'h0;
                oe_q <= 1'b0;
                sub_q <= sub_q + 8'h01;
                st_q <= ST_RACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                oe_q <= ~tx_q[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              hack_q <= ~sda_bit;
            end
            // host ack fetches the next byte, a nack ends the read
            if (scl_fall) begin
              if (hack_q) begin
                tx_q <= rd_data;
                oe_q <= ~rd_data[7];
                st_q <= ST_RD;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          ST_IDLE: begin
            oe_q <= 1'b0;
          end
          default: begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // address regions: page select everywhere, book on page 0, control space on book 0 page 0
  wire sub_ok = ~wr_addr_q[7];
  wire in_ctl = (page_q == 8'h00) && (book_q == 8'h00);
  wire wr_page = wr_stb_q & sub_ok & (wr_addr_q[6:0] == `ACR_OFS_PAGE);
  wire wr_book = wr_stb_q & sub_ok & (page_q == 8'h00) & (wr_addr_q[6:0] == `ACR_OFS_BOOK);
  wire wr_any = wr_stb_q & sub_ok & ~wr_page & ~wr_book;
  wire wr_ctl = wr_any & in_ctl;
  wire wr_coef = wr_any & ~in_ctl & ~clr_busy_q;
  wire wr_rst_reg = wr_ctl & (wr_addr_q[6:0] == `ACR_OFS_RESET_CONTROL);
  wire [COEF_AW-1:0] coef_wr_idx = {page_q[COEF_PAGE_BITS-1:0], wr_addr_q[6:0]};
  wire [COEF_AW-1:0] coef_rd_idx = {page_q[COEF_PAGE_BITS-1:0], sub_q[6:0]};

  // reset strobes act one cycle after the write; the bits themselves never store
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      full_rst_q <= 1'b0;
      reg_rst_q <= 1'b0;
    end else begin
      full_rst_q <= wr_rst_reg & wr_data_q[`ACR_FULL_RESET_BIT];
      reg_rst_q <= wr_rst_reg & wr_data_q[`ACR_REG_RESET_BIT];
    end
  end

  // control registers; writes keep reserved bits at their reset value
  always @(posedge i_clk_sys) begin
    if (i_rst || full_rst_q || reg_rst_q) begin
      for (i = 0; i < 128; i = i + 1) begin
        ctl_q[i] <= acr_rst_val(i[6:0]);
      end
      page_q <= 8'h00;
      book_q <= 8'h00;
    end else begin
      if (wr_page) begin
        page_q <= wr_data_q;
      end
      if (wr_book) begin
        book_q <= wr_data_q;
      end
      if (wr_ctl) begin
        ctl_q[wr_addr_q[6:0]] <= (wr_data_q & acr_mask(wr_addr_q[6:0])) |
          (acr_rst_val(wr_addr_q[6:0]) & ~acr_mask(wr_addr_q[6:0]));
      end
    end
  end

  // processor clear sweep; only a full core reset or i_rst starts it
  always @(posedge i_clk_sys) begin
    if (i_rst || full_rst_q) begin
      clr_busy_q <= 1'b1;
      clr_cnt_q <= {COEF_AW{1'b0}};
    end else if (clr_busy_q) begin
      clr_cnt_q <= clr_cnt_q + 1'b1;
      if (&clr_cnt_q) begin
        clr_busy_q <= 1'b0;
      end
    end
  end

  // coefficient memory; no reset so it maps to plain ram, register reset never touches it
  always @(posedge i_clk_sys) begin
    if (clr_busy_q) begin
      coef_q[clr_cnt_q] <= 8'h00;
    end else if (wr_coef) begin
      coef_q[coef_wr_idx] <= wr_data_q;
    end
  end

  // read mux for the serial slave; half-cleared memory reads zero while sweeping
  always @* begin
    rd_data = 8'h00;
    if (!sub_q[7]) begin
      if (sub_q[6:0] == `ACR_OFS_PAGE) begin
        rd_data = page_q;
      end else if (page_q == 8'h00 && sub_q[6:0] == `ACR_OFS_BOOK) begin
        rd_data = book_q;
      end else if (in_ctl) begin
        case (sub_q[6:0])
          `ACR_OFS_DIE_REVISION: rd_data = DIE_REVISION;
          `ACR_OFS_POWER_STATE: rd_data = {6'h00, dev_state[`ACR_STATE_MSB:`ACR_STATE_LSB]};
          `ACR_OFS_MUTE_STATE: rd_data = {7'h00, dev_state[`ACR_MUTE_BIT]};
          default: rd_data = ctl_q[sub_q[6:0]];
        endcase
      end else if (!clr_busy_q) begin
        rd_data = coef_q[coef_rd_idx];
      end
    end
  end

  // flags reserved frequency or modulation codes so the power stage can hold off
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= ((pwr_cfg[`ACR_FSW_MSB:`ACR_FSW_LSB] == `ACR_FSW_384K) ||
        (pwr_cfg[`ACR_FSW_MSB:`ACR_FSW_LSB] == `ACR_FSW_480K) ||
        (pwr_cfg[`ACR_FSW_MSB:`ACR_FSW_LSB] == `ACR_FSW_576K) ||
        (pwr_cfg[`ACR_FSW_MSB:`ACR_FSW_LSB] == `ACR_FSW_768K)) &&
        ((pwr_cfg[`ACR_MOD_MSB:`ACR_MOD_LSB] == `ACR_MOD_TWO_LEVEL) ||
        (pwr_cfg[`ACR_MOD_MSB:`ACR_MOD_LSB] == `ACR_MOD_SINGLE_SIDED) ||
        (pwr_cfg[`ACR_MOD_MSB:`ACR_MOD_LSB] == `ACR_MOD_HYBRID));
    end
  end

  // open-drain data: only ever pulls low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = oe_q;
  // configuration fields straight from the register flops
  assign o_switching_frequency_select = pwr_cfg[`ACR_FSW_MSB:`ACR_FSW_LSB];
  assign o_parallel_bridge_select = pwr_cfg[`ACR_PARALLEL_BRIDGE_BIT];
  assign o_modulation_scheme_select = pwr_cfg[`ACR_MOD_MSB:`ACR_MOD_LSB];
  assign o_power_stage_valid = valid_q;
  assign o_device_state = dev_state[`ACR_STATE_MSB:`ACR_STATE_LSB];
  assign o_dsp_hold = dev_state[`ACR_DSP_HOLD_BIT];
  assign o_mute = dev_state[`ACR_MUTE_BIT];
  assign o_full_core_reset = full_rst_q;
  assign o_coef_clear_busy = clr_busy_q;
  assign o_page = page_q;
  assign o_book = book_q;

endmodule

`default_nettype wire

// [sim/acr_bank_props.sv]
`timescale 1ns/10ps
`default_nettype none
module acr_bank_props #(
  parameter COEF_PAGE_BITS = 1
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  input wire o_sda_out,
  input wire o_sda_oe,
  input wire [2:0] o_switching_frequency_select,
  input wire o_parallel_bridge_select,
  input wire [1:0] o_modulation_scheme_select,
  input wire o_power_stage_valid,
  input wire [1:0] o_device_state,
  input wire o_dsp_hold,
  input wire o_mute,
  input wire o_full_core_reset,
  input wire o_coef_clear_busy,
  input wire [7:0] o_page,
  input wire [7:0] o_book
);
  localparam int SWEEP = 2 ** (COEF_PAGE_BITS + 7);
  logic [15:0] busy_cnt_q;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // sweep length counter; a sweep cut short would leave stale coefficients behind
  always @(posedge i_clk_sys) begin
    if (i_rst || !o_coef_clear_busy) busy_cnt_q <= 16'h0;
    else busy_cnt_q <= busy_cnt_q + 16'h1;
  end
  sequence s_one_pulse;
    o_full_core_reset ##1 !o_full_core_reset;
  endsequence
  sequence s_sweep_runs;
    o_coef_clear_busy [*8];
  endsequence
  property p_core_pulse;
    $rose(o_full_core_reset) |-> s_one_pulse;
  endproperty
  property p_core_sweep;
    o_full_core_reset |=> s_sweep_runs;
  endproperty
  property p_sweep_cause;
    $rose(o_coef_clear_busy) |-> $past(o_full_core_reset);
  endproperty
  property p_sweep_len;
    $fell(o_coef_clear_busy) |-> busy_cnt_q >= SWEEP - 2 && busy_cnt_q <= SWEEP + 2;
  endproperty
  property p_core_regs;
    o_full_core_reset |=> o_page == 8'h00 && o_book == 8'h00 && o_dsp_hold
      && o_switching_frequency_select == 3'h0 && o_device_state == 2'h0;
  endproperty
  property p_reset_vals;
    $fell(i_rst) |-> o_switching_frequency_select == 3'h0 && !o_parallel_bridge_select
      && o_modulation_scheme_select == 2'h0 ##1 o_power_stage_valid;
  endproperty
  property p_code_valid;
    !$past(i_rst) |-> o_power_stage_valid == (($past(o_switching_frequency_select)
      inside {3'h0, 3'h2, 3'h3, 3'h4}) && $past(o_modulation_scheme_select) != 2'h3);
  endproperty
  property p_book_page;
    $changed(o_book) && o_book != 8'h00 |-> $past(o_page) == 8'h00;
  endproperty
  property p_oe_scl_low;
    $changed(o_sda_oe) |-> !$past(i_scl);
  endproperty
  a_core_pulse: assert property (p_core_pulse) else $error("core reset not one cycle");
  a_core_sweep: assert property (p_core_sweep) else $error("no clear after core reset");
  a_sweep_cause: assert property (p_sweep_cause) else $error("clear without core reset");
  a_sweep_len: assert property (p_sweep_len) else $error("clear sweep wrong length");
  a_core_regs: assert property (p_core_regs) else $error("regs kept over core reset");
  a_reset_vals: assert property (p_reset_vals) else $error("power stage reset wrong");
  a_code_valid: assert property (p_code_valid) else $error("valid flag wrong");
  a_book_page: assert property (p_book_page) else $error("book set off page zero");
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved with scl high");
endmodule
bind acr_amp_control_register_bank acr_bank_props #(.COEF_PAGE_BITS(COEF_PAGE_BITS)) u_props (
  .i_clk_sys, .i_rst, .i_scl, .i_sda, .o_sda_out, .o_sda_oe, .o_switching_frequency_select,
  .o_parallel_bridge_select, .o_modulation_scheme_select, .o_power_stage_valid,
  .o_device_state, .o_dsp_hold, .o_mute, .o_full_core_reset, .o_coef_clear_busy, .o_page,
  .o_book);
`default_nettype wire

// [sim/acr_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
// i2c host; each bus phase lasts ten system clocks, well above the synchroniser delay
module acr_host_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic hp;
    repeat (10) @(posedge i_clk);
  endtask
  // start or repeated start: sda released before scl rises, then pulled
  task automatic start;
    o_sda_low <= 1'b0;
    hp;
    o_scl <= 1'b1;
    hp;
    o_sda_low <= 1'b1;
    hp;
    o_scl <= 1'b0;
    hp;
  endtask
  task automatic stop;
    o_sda_low <= 1'b1;
    hp;
    o_scl <= 1'b1;
    hp;
    o_sda_low <= 1'b0;
    hp;
  endtask
  // one bit; the line is sampled at the end of the high phase
  task automatic bit_x(input logic b, output logic r);
    o_sda_low <= ~b;
    hp;
    o_scl <= 1'b1;
    hp;
    r = i_sda;
    o_scl <= 1'b0;
    hp;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(a, k);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] s, input logic [7:0] d,
                    output logic ok);
    logic k1, k2, k3;
    logic [7:0] x;
    start;
    xfer({a, 1'b0}, 1'b1, x, k1);
    xfer(s, 1'b1, x, k2);
    xfer(d, 1'b1, x, k3);
    stop;
    ok = !(k1 || k2 || k3);
  endtask
  // single-byte read, closed with a not-acknowledge
  task automatic rd(input logic [6:0] a, input logic [7:0] s, output logic [7:0] q,
                    output logic ok);
    logic k1, k2, k3, kn;
    logic [7:0] x;
    start;
    xfer({a, 1'b0}, 1'b1, x, k1);
    xfer(s, 1'b1, x, k2);
    start;
    xfer({a, 1'b1}, 1'b1, x, k3);
    xfer(8'hff, 1'b1, q, kn);
    stop;
    ok = !(k1 || k2 || k3);
  endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module tb_top;
  localparam logic [6:0] DEV = 7'h2a;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic ok;
  logic [7:0] q;
  logic [7:0] w;
  int mismatches = 0;
  int compares = 0;
  int pulses = 0;
  wire scl, sda_low, sda_oe, sda_out, fcr, busy, psv, pb, hold, mute;
  wire [2:0] fsw;
  wire [1:0] md, dst;
  wire [7:0] page, book;
  // open-drain line with a pull-up: low while either side pulls
  wire sda = !(sda_low || sda_oe);
  // rows: offset, written value, value read back
  logic [23:0] rows [20] = '{24'h020000, 24'h022121, 24'h023636, 24'h024444, 24'h021313,
    24'h02ff77, 24'h030000, 24'h030101, 24'h030a0a, 24'h031313, 24'h03ff1b, 24'h0fff08,
    24'h28fff8, 24'h4ca5a5, 24'h67005a, 24'h37ff00, 24'h04ff00, 24'h90ff00, 24'h68ff03,
    24'h69ff01};
  initial begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  acr_host_model host (.i_clk(i_clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  // die revision value is arbitrary
  acr_amp_control_register_bank #(.DEV_ADDR(DEV), .DIE_REVISION(8'h5a), .COEF_PAGE_BITS(1)) uut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .o_switching_frequency_select(fsw), .o_parallel_bridge_select(pb),
    .o_modulation_scheme_select(md), .o_power_stage_valid(psv), .o_device_state(dst),
    .o_dsp_hold(hold), .o_mute(mute), .o_full_core_reset(fcr), .o_coef_clear_busy(busy),
    .o_page(page), .o_book(book));
  // pulse count catches a stuck or doubled core reset
  always @(posedge i_clk_sys) begin
    if (fcr === 1'b1) pulses <= pulses + 1;
  end
  function automatic logic code_ok(input logic [7:0] v);
    return (v[6:4] inside {3'h0, 3'h2, 3'h3, 3'h4}) && (v[1:0] != 2'h3);
  endfunction
  task automatic wr_ok(input logic [7:0] s, input logic [7:0] d);
    host.wr(DEV, s, d, ok);
    `CHK(ok, 1'b1)
  endtask
  task automatic rd_chk(input logic [7:0] s, input logic [7:0] e);
    host.rd(DEV, s, q, ok);
    `CHK({ok, q}, {1'b1, e})
  endtask
  // bounded wait; the sweep is far shorter than the limit
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge i_clk_sys);
      n++;
    end
    `CHK(busy, 1'b0)
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    // the run needs about 65k clocks; the limit stays below 100k clocks
    #800us;
    mismatches++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(negedge i_clk_sys);
    `CHK(busy, 1'b1)
    wait_idle;
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h10);
    foreach (rows[i]) begin
      w = rows[i][15:8];
      wr_ok(rows[i][23:16], w);
      rd_chk(rows[i][23:16], rows[i][7:0]);
      if (rows[i][23:16] == 8'h02)
        `CHK({fsw, pb, md, psv}, {w[6:4], w[2], w[1:0], code_ok(w)})
      if (rows[i][23:16] == 8'h03)
        `CHK({hold, mute, dst}, {w[4:3], w[1:0]})
    end
    // foreign address is ignored
    host.wr(7'h2b, 8'h02, 8'h00, ok);
    `CHK(ok, 1'b0)
    rd_chk(8'h02, 8'h77);
    wr_ok(8'h00, 8'h01);
    `CHK(page, 8'h01)
    wr_ok(8'h10, 8'h5a);
    rd_chk(8'h10, 8'h5a);
    // book select off page 0 lands in coefficient memory instead
    wr_ok(8'h7f, 8'h07);
    `CHK(book, 8'h00)
    wr_ok(8'h00, 8'h00);
    wr_ok(8'h7f, 8'h03);
    `CHK(book, 8'h03)
    wr_ok(8'h7f, 8'h00);
    wr_ok(8'h01, 8'h01);
    `CHK({fsw, pb, md, hold, dst}, {6'h0, 1'b1, 2'h0})
    rd_chk(8'h01, 8'h00);
    wr_ok(8'h00, 8'h01);
    rd_chk(8'h10, 8'h5a);
    wr_ok(8'h00, 8'h00);
    wr_ok(8'h01, 8'h10);
    `CHK({pulses, busy}, {32'd1, 1'b1})
    wait_idle;
    rd_chk(8'h03, 8'h10);
    wr_ok(8'h00, 8'h01);
    rd_chk(8'h10, 8'h00);
    // mid-run reset: power stage and page return to their rest state, the clear sweep restarts
    wr_ok(8'h00, 8'h00);
    wr_ok(8'h02, 8'h36);
    `CHK(fsw, 3'h3)
    wr_ok(8'h00, 8'h01);
    i_rst <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(negedge i_clk_sys);
    `CHK({fsw, pb, md, hold, dst}, {6'h00, 1'b1, 2'h0})
    `CHK({busy, page, sda_out}, {1'b1, 8'h00, 1'b0})
    wait_idle;
    rd_chk(8'h02, 8'h00);
    stop_test;
  end
endmodule
`default_nettype wire
